// file: shared/rcb_pkg.sv
// Constants and carrier types for the start-up reset and clock configuration block
package rcb_pkg;

  localparam int unsigned CLK_RATE_MHZ     = 100;
  localparam int unsigned PLL_LOCK_CYCLES  = 4096;
  localparam int unsigned RATIO_W          = 6;
  localparam int unsigned MULT_W           = 7;
  localparam int unsigned DIV_W            = 4;

  localparam logic [1:0] CLK_CFG_8         = 2'h0;
  localparam logic [1:0] CLK_CFG_32        = 2'h1;
  localparam logic [1:0] CLK_CFG_16        = 2'h2;
  localparam logic [RATIO_W-1:0] RATIO_8   = 6'h08;
  localparam logic [RATIO_W-1:0] RATIO_16  = 6'h10;
  localparam logic [RATIO_W-1:0] RATIO_32  = 6'h20;
  localparam logic [RATIO_W-1:0] RATIO_NONE = 6'h00;

  localparam int unsigned RUNRST_EN_BIT    = 0;

  typedef enum logic [1:0] {
    RCB_RESET,
    RCB_LOCK_WAIT,
    RCB_RUN
  } rcb_state_e;

  // Software frequency change request
  typedef struct packed {
    logic              wr;
    logic [MULT_W-1:0] mult;
    logic [DIV_W-1:0]  div;
  } rcb_pll_wr_s;

  // PLL setting in force
  typedef struct packed {
    logic              locked;
    logic [MULT_W-1:0] mult;
    logic [DIV_W-1:0]  div;
  } rcb_pll_s;

endpackage

// file: core/rcb_top.sv
// Start-up sequencer: clock ratio strap, PLL lock wait, boot strap, shared reset pin
// Summary of operation
// - Strap 00 gives 8:1, 01 gives 32:1, 10 gives 16:1, 11 reserved.
// - After core leaves reset, software may load new PLL multiplier and divider.
// - After reset release wait 4096 input clocks, then core runs from reset vector.
// - Shared pin is reset output unless control bit 0 selects running-reset input.
`timescale 1ns/1ns
`default_nettype none
module rcb_top #(
  parameter int unsigned LOCK_CYCLES = rcb_pkg::PLL_LOCK_CYCLES
) (
  input  wire logic                     clock_i,
  input  wire logic                     nrst_i,
  input  wire logic [1:0]               clk_cfg_i,
  input  wire logic [2:0]               boot_cfg_i,
  input  wire logic                     soft_reset_i,
  input  wire logic [7:0]               running_reset_control_reg_i,
  input  wire rcb_pkg::rcb_pll_wr_s     pll_wr_i,
  input  wire logic                     reset_pin_i,
  output logic                          reset_pin_o,
  output logic                          reset_pin_oe_o,
  output var  rcb_pkg::rcb_pll_s        pll_o,
  output logic [rcb_pkg::RATIO_W-1:0]   clk_ratio_o,
  output logic                          ratio_reserved_o,
  output logic [2:0]                    boot_mode_o,
  output logic                          core_run_o,
  output logic                          running_reset_o
);

  localparam int unsigned CNT_W = $clog2(LOCK_CYCLES + 1);

  rcb_pkg::rcb_state_e state;
  logic [CNT_W-1:0]    lock_cnt;
  logic [1:0]          cfg_s1;
  logic [1:0]          cfg_s2;
  logic [2:0]          boot_s1;
  logic [2:0]          boot_s2;
  logic [2:0]          pin_s;
  logic                run_en;

  // Two-flop synchronisers for pins; pin_s[2] is a third stage for edge detect
  always_ff @(posedge clock_i)
  begin
    cfg_s1  <= clk_cfg_i;
    cfg_s2  <= cfg_s1;
    boot_s1 <= boot_cfg_i;
    boot_s2 <= boot_s1;
    pin_s   <= {pin_s[1:0], reset_pin_i};
  end

  assign run_en = running_reset_control_reg_i[rcb_pkg::RUNRST_EN_BIT];

  // Sequencer state
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      state <= rcb_pkg::RCB_RESET;
    end
    else
    begin
      unique case (state)
        rcb_pkg::RCB_RESET:
        begin
          state <= rcb_pkg::RCB_LOCK_WAIT;
        end
        rcb_pkg::RCB_LOCK_WAIT:
        begin
          if (lock_cnt == CNT_W'(LOCK_CYCLES))
            state <= rcb_pkg::RCB_RUN;
        end
        rcb_pkg::RCB_RUN:
        begin
          // Soft or running reset reruns the lock wait
          if (soft_reset_i || running_reset_o)
            state <= rcb_pkg::RCB_LOCK_WAIT;
        end
      endcase
    end
  end

  // Lock wait counter, restarted on every entry to the wait
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      lock_cnt <= '0;
    end
    else if (state == rcb_pkg::RCB_RESET ||
             (state == rcb_pkg::RCB_RUN && (soft_reset_i || running_reset_o)))
    begin
      lock_cnt <= CNT_W'(1);
    end
    else if (state == rcb_pkg::RCB_LOCK_WAIT && lock_cnt != CNT_W'(LOCK_CYCLES))
    begin
      lock_cnt <= lock_cnt + CNT_W'(1);
    end
  end

  // Straps latched while held in reset and in RCB_RESET, frozen once the sequencer leaves RCB_RESET
  always_ff @(posedge clock_i)
  begin
    if (state == rcb_pkg::RCB_RESET || !nrst_i)
    begin
      unique case (cfg_s2)
        rcb_pkg::CLK_CFG_8:  clk_ratio_o <= rcb_pkg::RATIO_8;
        rcb_pkg::CLK_CFG_32: clk_ratio_o <= rcb_pkg::RATIO_32;
        rcb_pkg::CLK_CFG_16: clk_ratio_o <= rcb_pkg::RATIO_16;
        default:             clk_ratio_o <= rcb_pkg::RATIO_NONE;
      endcase
      ratio_reserved_o <= (cfg_s2 == 2'h3);
    end
  end

  // Boot mode captured at every nrst_i or soft reset, but not at running reset
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i || soft_reset_i)
      boot_mode_o <= boot_s2;
  end

  // PLL setting: strap ratio at reset, software writes only while running
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      pll_o <= '0;
    end
    else
    begin
      pll_o.locked <= (state == rcb_pkg::RCB_RUN);
      if (state == rcb_pkg::RCB_RESET)
      begin
        pll_o.mult <= rcb_pkg::MULT_W'(clk_ratio_o);
        pll_o.div  <= rcb_pkg::DIV_W'(1);
      end
      else if (pll_wr_i.wr && state == rcb_pkg::RCB_RUN)
      begin
        pll_o.mult <= pll_wr_i.mult;
        pll_o.div  <= pll_wr_i.div;
      end
    end
  end

  // Shared pin role and drive
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      reset_pin_oe_o  <= 1'b1;
      reset_pin_o     <= 1'b0;
      running_reset_o <= 1'b0;
    end
    else
    begin
      reset_pin_oe_o  <= !run_en;
      reset_pin_o     <= (state == rcb_pkg::RCB_RUN);
      running_reset_o <= run_en && !pin_s[1] && pin_s[2] && state == rcb_pkg::RCB_RUN;
    end
  end

  assign core_run_o = (state == rcb_pkg::RCB_RUN);

endmodule
`default_nettype wire

// file: test/rcb_board.sv
// Board model of the shared reset pin
`timescale 1ns/1ns
`default_nettype none
module rcb_board (
  input  wire logic drv_i,
  input  wire logic oe_i,
  input  wire logic press_i,
  output logic      pin_o
);
  // Pull-up holds the pin high unless pressed
  assign pin_o = oe_i ? drv_i : !press_i;
endmodule
`default_nettype wire

// file: test/rcb_chk.sv
// Port assertions for the start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module rcb_chk #(
  parameter int unsigned LOCK_CYCLES = 8
) (
  input wire logic                        clock_i,
  input wire logic                        nrst_i,
  input wire logic [1:0]                  clk_cfg_i,
  input wire logic [7:0]                  running_reset_control_reg_i,
  input wire rcb_pkg::rcb_pll_wr_s        pll_wr_i,
  input wire rcb_pkg::rcb_pll_s           pll_o,
  input wire logic [rcb_pkg::RATIO_W-1:0] clk_ratio_o,
  input wire logic                        reset_pin_o,
  input wire logic                        reset_pin_oe_o,
  input wire logic                        core_run_o,
  input wire logic                        running_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire logic rr_en = running_reset_control_reg_i[0];
  a_ratio_map: assert property (core_run_o |-> clk_ratio_o == (clk_cfg_i == 2'h0 ? rcb_pkg::RATIO_8 :
    clk_cfg_i == 2'h1 ? rcb_pkg::RATIO_32 : clk_cfg_i == 2'h2 ? rcb_pkg::RATIO_16 : rcb_pkg::RATIO_NONE))
    else $error("ratio does not match strap");
  a_pll_load: assert property (core_run_o && pll_wr_i.wr |=> pll_o[10:0] == $past(pll_wr_i[10:0]))
    else $error("PLL write not applied");
  a_lock_wait: assert property ($rose(core_run_o) |-> !$past(core_run_o, LOCK_CYCLES))
    else $error("core started before lock wait");
  a_pin_release: assert property ($rose(core_run_o) && !rr_en |-> !reset_pin_o ##1 reset_pin_o)
    else $error("reset pin release wrong");
  a_role_input: assert property (rr_en [*3] |-> !reset_pin_oe_o)
    else $error("pin driven in input role");
  a_role_output: assert property (!rr_en [*3] |-> reset_pin_oe_o)
    else $error("pin not driven in output role");
  a_pulse_stop: assert property (running_reset_o |=> !core_run_o)
    else $error("core kept running after running reset");
  c_start: cover property ($rose(core_run_o));
  c_pulse: cover property (running_reset_o);
  c_write: cover property (core_run_o && pll_wr_i.wr);
endmodule
bind rcb_top rcb_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.*);
`default_nettype wire

// file: test/rcb_tb_top.sv
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module rcb_tb_top;
  localparam int unsigned LOCK = 8;
  logic clock_i = 0, nrst_i = 0, soft_reset_i = 0, press = 0, reset_pin_i, reset_pin_o, reset_pin_oe_o;
  logic ratio_reserved_o, core_run_o, running_reset_o;
  logic [1:0] clk_cfg_i = 0;
  logic [2:0] boot_cfg_i = 3'h5, boot_mode_o;
  logic [7:0] running_reset_control_reg_i = 0;
  logic [5:0] clk_ratio_o, tab [4] = '{rcb_pkg::RATIO_8, rcb_pkg::RATIO_32, rcb_pkg::RATIO_16, rcb_pkg::RATIO_NONE};
  rcb_pkg::rcb_pll_wr_s pll_wr_i = '0;
  rcb_pkg::rcb_pll_s pll_o;
  int n_errors = 0, total_checks = 0, cyc = 0, n;
  rcb_top #(.LOCK_CYCLES(LOCK)) dut (.*);
  rcb_board board (.drv_i(reset_pin_o), .oe_i(reset_pin_oe_o), .press_i(press), .pin_o(reset_pin_i));
  initial forever #5 clock_i = !clock_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_wait();
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (core_run_o !== 1'b1 && n < 50);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clock_i) nrst_i <= 0;
      @(posedge clock_i) clk_cfg_i <= 2'(c);
      repeat (16) @(posedge clock_i);
      nrst_i <= 1;
      run_wait();
      chk(n, LOCK + 2);
      chk(clk_ratio_o, tab[c]);
      chk(ratio_reserved_o, c == 3);
      chk(boot_mode_o, 3'h5);
      chk(reset_pin_o, 0);
      @(negedge clock_i) chk(reset_pin_o, 1);
      $display("strap test %0d done", c);
    end
    @(posedge clock_i) pll_wr_i <= {1'b1, 7'h2A, 4'h3};
    @(posedge clock_i) pll_wr_i <= {1'b1, 7'h11, 4'h5};
    @(negedge clock_i) chk(pll_o[10:0], {7'h2A, 4'h3});
    @(posedge clock_i) pll_wr_i <= '0;
    running_reset_control_reg_i <= 8'h01;
    @(negedge clock_i) chk(pll_o[10:0], {7'h11, 4'h5});
    $display("pll test done");
    repeat (3) @(negedge clock_i);
    chk(reset_pin_oe_o, 0);
    @(posedge clock_i) press <= 1;
    n = 0;
    repeat (8) @(negedge clock_i) n += running_reset_o;
    chk(n, 1);
    chk(core_run_o, 0);
    @(posedge clock_i) press <= 0;
    run_wait();
    chk(core_run_o, 1);
    $display("running reset test done");
    @(posedge clock_i) boot_cfg_i <= 3'h2;
    repeat (3) @(posedge clock_i);
    soft_reset_i <= 1;
    @(posedge clock_i) soft_reset_i <= 0;
    run_wait();
    chk(n, LOCK + 1);
    chk(boot_mode_o, 3'h2);
    $display("soft reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
